// ===== logic/tmpl_pkg.sv
package tmpl_pkg;
  // tags of the template and of its nested objects
  localparam logic [7:0] TAG_TEMPLATE = 8'hA5;
  localparam logic [7:0] TAG_CHAR = 8'h80;
  localparam logic [7:0] TAG_PWR = 8'h81;
  localparam logic [7:0] TAG_MIN_CLK = 8'h82;
  localparam logic [7:0] TAG_FREE_MEM = 8'h83;
  localparam logic [7:0] TAG_FILE_DETAILS = 8'h84;
  localparam logic [7:0] TAG_RESERVED_SIZE = 8'h85;
  localparam logic [7:0] TAG_MAX_SIZE = 8'h86;
  localparam logic [7:0] TAG_COMMANDS = 8'h87;
  localparam logic [7:0] TAG_ENV = 8'h88;
  localparam logic [7:0] TAG_SECURE_TRANSPORT = 8'h89;
  localparam logic [7:0] PRIVATE_TAG_MASK = 8'hC0;
  // length bytes of the objects built here
  localparam logic [7:0] LEN_CHAR = 8'h01;
  localparam logic [7:0] LEN_PWR = 8'h03;
  localparam logic [7:0] LEN_MIN_CLK = 8'h01;
  localparam logic [7:0] LEN_MAX = 8'h02;
  localparam logic [7:0] LEN_CMD = 8'h01;
  localparam logic [7:0] LEN_ENV = 8'h01;
  localparam logic [7:0] LEN_PRIV = 8'h01;
  // characteristics byte: reserved bits b8 and b2
  localparam logic [7:0] CHAR_RESERVED_MASK = 8'h82;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHAR = 8'h04;
  localparam logic [7:0] ADDR_MISC = 8'h08;
  localparam logic [7:0] ADDR_PRIV = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_PWR_BASE = 8'h20;
  localparam logic [7:0] ADDR_CLK_BASE = 8'h40;
  // control register fields
  localparam int CTRL_KIND_LSB = 0;
  localparam int CTRL_START_BIT = 8;
  localparam int CTRL_CHAR_EN_BIT = 16;
  localparam int CTRL_CMD_EN_BIT = 17;
  localparam int CTRL_MAX_EN_BIT = 18;
  localparam int CTRL_ENV_SUP_BIT = 19;
  localparam int CTRL_PRIV_EN_BIT = 20;
  localparam int CTRL_NPWR_LSB = 24;
  localparam int CTRL_NCLK_LSB = 28;
  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_POLICY_LSB = 1;
  localparam int STAT_CLASS_LSB = 5;
  localparam int STAT_LEN_LSB = 8;
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] CHAR_RESET = 8'h00;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    KIND_ROOT = 3'h0,
    KIND_APP = 3'h1,
    KIND_PLAIN = 3'h2,
    KIND_EF = 3'h3,
    KIND_EF_BER = 3'h4
  } file_kind_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_TAG = 4'b0010,
    ST_LEN = 4'b0100,
    ST_BODY = 4'b1000
  } gen_state_t;

  // bit order follows tag order, private object last
  typedef enum logic [6:0] {
    OBJ_CHAR = 7'b0000001,
    OBJ_PWR = 7'b0000010,
    OBJ_CLK = 7'b0000100,
    OBJ_MAX = 7'b0001000,
    OBJ_CMD = 7'b0010000,
    OBJ_ENV = 7'b0100000,
    OBJ_PRIV = 7'b1000000
  } obj_t;
endpackage

// ===== logic/char_codec.sv
`timescale 1ns/1ns
// builds the characteristics byte and decodes its clock-stop policy
module char_codec (
  input wire logic [7:0] raw,
  output logic [7:0] char_byte,
  output logic stop_any,
  output logic stop_high,
  output logic stop_low,
  output logic stop_never,
  output logic [2:0] classes
);
  logic [1:0] lvl;

  // reserved bits forced low, level code is b4,b3
  always_comb begin
    char_byte = raw & ~tmpl_pkg::CHAR_RESERVED_MASK;
    lvl = raw[3:2];
    classes = raw[6:4];
    stop_any = raw[0] && lvl != 2'h3;
    stop_high = raw[0] ? (lvl != 2'h3) : (lvl == 2'h1);
    stop_low = raw[0] ? (lvl != 2'h3) : (lvl == 2'h2);
    stop_never = !stop_high && !stop_low;
  end
endmodule

// ===== logic/template_encoder.sv
`timescale 1ns/1ns
module template_encoder #(
  parameter int ADDR_W = 8,
  parameter int N_PWR = 4,
  parameter int N_CLK = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready
);
  typedef struct packed {
    tmpl_pkg::gen_state_t st;
    tmpl_pkg::obj_t obj;
    logic [2:0] idx;
    logic [2:0] rep;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_last;
    logic tx_tag;
    logic [31:0] ctrl;
    logic [7:0] char_raw;
    logic [31:0] misc;
    logic [15:0] priv;
    logic [N_PWR-1:0][23:0] pwr;
    logic [N_CLK-1:0][7:0] clk;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] last_fired;
    logic last_was_tag;
    logic char_next;
    logic [7:0] last_tag;
    logic seen_char;
    logic seen_cmd;
    logic seen_priv;
    logic [2:0] pwr_seen;
  } state_t;

  state_t q;
  state_t d;
  logic [7:0] char_byte;
  logic stop_any;
  logic stop_high;
  logic stop_low;
  logic stop_never;
  logic [2:0] classes;
  tmpl_pkg::file_kind_t kind;
  logic [2:0] npwr;
  logic [2:0] nclk;
  logic [6:0] pres;
  logic [6:0] above;
  logic [6:0] nxt;
  logic [6:0] first;
  logic [7:0] total_len;
  logic [2:0] obj_size;
  logic [2:0] obj_reps;
  logic [7:0] cur_byte;
  logic busy;
  logic load;
  logic fire;
  logic wr;
  logic start;
  logic wr_hit;
  logic [ADDR_W-1:0] wa;
  logic [ADDR_W-1:0] ra;
  logic [31:0] mrg;

  char_codec u_codec (
    .raw(q.char_raw),
    .char_byte(char_byte),
    .stop_any(stop_any),
    .stop_high(stop_high),
    .stop_low(stop_low),
    .stop_never(stop_never),
    .classes(classes)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // configuration view and objects present for this file kind
  always_comb begin
    kind = tmpl_pkg::file_kind_t'(q.ctrl[tmpl_pkg::CTRL_KIND_LSB +: 3]);
    npwr = q.ctrl[tmpl_pkg::CTRL_NPWR_LSB +: 3];
    nclk = q.ctrl[tmpl_pkg::CTRL_NCLK_LSB +: 3];
    if (npwr > 3'(N_PWR)) begin
      npwr = 3'(N_PWR);
    end
    if (nclk > 3'(N_CLK)) begin
      nclk = 3'(N_CLK);
    end
    pres[0] = kind == tmpl_pkg::KIND_ROOT || q.ctrl[tmpl_pkg::CTRL_CHAR_EN_BIT];
    pres[1] = kind == tmpl_pkg::KIND_APP && npwr != 3'h0;
    pres[2] = kind == tmpl_pkg::KIND_APP && nclk != 3'h0;
    pres[3] = kind == tmpl_pkg::KIND_EF_BER && q.ctrl[tmpl_pkg::CTRL_MAX_EN_BIT];
    pres[4] = kind == tmpl_pkg::KIND_ROOT || (q.ctrl[tmpl_pkg::CTRL_CMD_EN_BIT] &&
              (kind == tmpl_pkg::KIND_APP || kind == tmpl_pkg::KIND_PLAIN));
    pres[5] = kind == tmpl_pkg::KIND_ROOT && q.ctrl[tmpl_pkg::CTRL_ENV_SUP_BIT];
    pres[6] = q.ctrl[tmpl_pkg::CTRL_PRIV_EN_BIT];
    first = pres & (~pres + 7'h01);
    above = pres & ~(q.obj | (q.obj - 7'h01));
    nxt = above & (~above + 7'h01); // next object strictly after current, tag order
    total_len = (pres[0] ? 8'h03 : 8'h00) + (pres[1] ? 8'(5 * npwr) : 8'h00) +
                (pres[2] ? 8'(3 * nclk) : 8'h00) + (pres[3] ? 8'h04 : 8'h00) +
                (pres[4] ? 8'h03 : 8'h00) + (pres[5] ? 8'h03 : 8'h00) + (pres[6] ? 8'h03 : 8'h00);
  end

  // byte selection inside the current object
  always_comb begin
    cur_byte = 8'h00;
    obj_size = 3'h3;
    obj_reps = 3'h1;
    unique case (q.obj)
      tmpl_pkg::OBJ_CHAR: begin
        cur_byte = q.idx == 3'h0 ? tmpl_pkg::TAG_CHAR : q.idx == 3'h1 ? tmpl_pkg::LEN_CHAR : char_byte;
      end
      tmpl_pkg::OBJ_PWR: begin
        obj_size = 3'h5;
        obj_reps = npwr;
        unique case (q.idx)
          3'h0: cur_byte = tmpl_pkg::TAG_PWR;
          3'h1: cur_byte = tmpl_pkg::LEN_PWR;
          3'h2: cur_byte = q.pwr[q.rep][23:16];
          3'h3: cur_byte = q.pwr[q.rep][15:8];
          default: cur_byte = q.pwr[q.rep][7:0];
        endcase
      end
      tmpl_pkg::OBJ_CLK: begin
        obj_reps = nclk;
        cur_byte = q.idx == 3'h0 ? tmpl_pkg::TAG_MIN_CLK : q.idx == 3'h1 ? tmpl_pkg::LEN_MIN_CLK : q.clk[q.rep];
      end
      tmpl_pkg::OBJ_MAX: begin
        obj_size = 3'h4;
        unique case (q.idx)
          3'h0: cur_byte = tmpl_pkg::TAG_MAX_SIZE;
          3'h1: cur_byte = tmpl_pkg::LEN_MAX;
          3'h2: cur_byte = q.misc[31:24];
          default: cur_byte = q.misc[23:16];
        endcase
      end
      tmpl_pkg::OBJ_CMD: begin
        cur_byte = q.idx == 3'h0 ? tmpl_pkg::TAG_COMMANDS : q.idx == 3'h1 ? tmpl_pkg::LEN_CMD : q.misc[7:0];
      end
      tmpl_pkg::OBJ_ENV: begin
        cur_byte = q.idx == 3'h0 ? tmpl_pkg::TAG_ENV : q.idx == 3'h1 ? tmpl_pkg::LEN_ENV : q.misc[15:8];
      end
      tmpl_pkg::OBJ_PRIV: begin
        cur_byte = q.idx == 3'h0 ? (q.priv[7:0] | tmpl_pkg::PRIVATE_TAG_MASK) :
                   q.idx == 3'h1 ? tmpl_pkg::LEN_PRIV : q.priv[15:8];
      end
    endcase
  end

  assign busy = q.st != tmpl_pkg::ST_IDLE || q.tx_valid;
  assign load = !q.tx_valid || tx_ready;
  assign fire = q.tx_valid && tx_ready;
  assign wr = q.aw_have && q.w_have && !q.bvalid;
  assign wa = q.aw_addr;
  assign ra = araddr;
  assign start = wr && wa == ADDR_W'(tmpl_pkg::ADDR_CTRL) && q.w_strb[1] &&
                 q.w_data[tmpl_pkg::CTRL_START_BIT] && !busy;

  // next state: bus slave, register file, byte generator
  always_comb begin
    d = q;
    wr_hit = 1'b0;
    mrg = 32'h0000_0000;
    // write address and data taken in either order
    if (awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (wr) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      if (wa == ADDR_W'(tmpl_pkg::ADDR_STATUS)) begin
        wr_hit = 1'b1;
      end
      if (wa == ADDR_W'(tmpl_pkg::ADDR_CTRL)) begin
        wr_hit = 1'b1;
        if (!busy) begin
          d.ctrl = merge(q.ctrl, q.w_data, q.w_strb) & ~(32'h1 << tmpl_pkg::CTRL_START_BIT);
        end
      end
      if (wa == ADDR_W'(tmpl_pkg::ADDR_CHAR)) begin
        wr_hit = 1'b1;
        if (!busy && q.w_strb[0]) begin
          d.char_raw = q.w_data[7:0];
        end
      end
      if (wa == ADDR_W'(tmpl_pkg::ADDR_MISC)) begin
        wr_hit = 1'b1;
        if (!busy) begin
          d.misc = merge(q.misc, q.w_data, q.w_strb);
        end
      end
      if (wa == ADDR_W'(tmpl_pkg::ADDR_PRIV)) begin
        wr_hit = 1'b1;
        if (!busy) begin
          mrg = merge({16'h0000, q.priv}, q.w_data, q.w_strb);
          d.priv = mrg[15:0];
        end
      end
      for (int i = 0; i < N_PWR; i++) begin
        if (wa == ADDR_W'(tmpl_pkg::ADDR_PWR_BASE + 8'(4 * i))) begin
          wr_hit = 1'b1;
          if (!busy) begin
            mrg = merge({8'h00, q.pwr[i]}, q.w_data, q.w_strb);
            d.pwr[i] = mrg[23:0];
          end
        end
      end
      for (int i = 0; i < N_CLK; i++) begin
        if (wa == ADDR_W'(tmpl_pkg::ADDR_CLK_BASE + 8'(4 * i))) begin
          wr_hit = 1'b1;
          if (!busy && q.w_strb[0]) begin
            d.clk[i] = q.w_data[7:0];
          end
        end
      end
      d.bresp = wr_hit ? tmpl_pkg::RESP_OKAY : tmpl_pkg::RESP_SLVERR;
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;
    // read answer one cycle after the address is taken
    if (rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = tmpl_pkg::RESP_OKAY;
      d.rdata = 32'h0000_0000;
      if (ra == ADDR_W'(tmpl_pkg::ADDR_CTRL)) begin
        d.rdata = q.ctrl;
      end else if (ra == ADDR_W'(tmpl_pkg::ADDR_CHAR)) begin
        d.rdata = {24'h000000, char_byte};
      end else if (ra == ADDR_W'(tmpl_pkg::ADDR_MISC)) begin
        d.rdata = q.misc;
      end else if (ra == ADDR_W'(tmpl_pkg::ADDR_PRIV)) begin
        d.rdata = {16'h0000, q.priv};
      end else if (ra == ADDR_W'(tmpl_pkg::ADDR_STATUS)) begin
        d.rdata[tmpl_pkg::STAT_BUSY_BIT] = busy;
        d.rdata[tmpl_pkg::STAT_POLICY_LSB +: 4] = {stop_never, stop_low, stop_high, stop_any};
        d.rdata[tmpl_pkg::STAT_CLASS_LSB +: 3] = classes;
        d.rdata[tmpl_pkg::STAT_LEN_LSB +: 8] = total_len;
      end else begin
        d.rresp = tmpl_pkg::RESP_SLVERR;
        for (int i = 0; i < N_PWR; i++) begin
          if (ra == ADDR_W'(tmpl_pkg::ADDR_PWR_BASE + 8'(4 * i))) begin
            d.rdata = {8'h00, q.pwr[i]};
            d.rresp = tmpl_pkg::RESP_OKAY;
          end
        end
        for (int i = 0; i < N_CLK; i++) begin
          if (ra == ADDR_W'(tmpl_pkg::ADDR_CLK_BASE + 8'(4 * i))) begin
            d.rdata = {24'h000000, q.clk[i]};
            d.rresp = tmpl_pkg::RESP_OKAY;
          end
        end
      end
    end
    d.arready = !d.rvalid;
    // byte generator, output register reloads when empty or taken
    if (fire) begin
      d.tx_valid = 1'b0;
      d.tx_last = 1'b0;
    end
    unique case (q.st)
      tmpl_pkg::ST_IDLE: begin
        if (start) begin
          d.st = tmpl_pkg::ST_TAG;
        end
      end
      tmpl_pkg::ST_TAG: begin
        if (load) begin
          d.tx_data = tmpl_pkg::TAG_TEMPLATE;
          d.tx_valid = 1'b1;
          d.tx_tag = 1'b0;
          d.st = tmpl_pkg::ST_LEN;
        end
      end
      tmpl_pkg::ST_LEN: begin
        if (load) begin
          d.tx_data = total_len;
          d.tx_valid = 1'b1;
          d.tx_tag = 1'b0;
          d.tx_last = pres == 7'h00;
          d.obj = pres == 7'h00 ? tmpl_pkg::OBJ_CHAR : tmpl_pkg::obj_t'(first); // keep a legal one-hot code
          d.idx = 3'h0;
          d.rep = 3'h0;
          d.st = pres == 7'h00 ? tmpl_pkg::ST_IDLE : tmpl_pkg::ST_BODY;
        end
      end
      tmpl_pkg::ST_BODY: begin
        if (load) begin
          d.tx_data = cur_byte;
          d.tx_valid = 1'b1;
          d.tx_tag = q.idx == 3'h0;
          d.idx = q.idx + 3'h1;
          if (q.idx == obj_size - 3'h1) begin
            d.idx = 3'h0;
            if (q.rep != obj_reps - 3'h1) begin
              d.rep = q.rep + 3'h1; // same tag repeated back to back, in stored order
            end else if (nxt == 7'h00) begin
              d.tx_last = 1'b1;
              d.st = tmpl_pkg::ST_IDLE;
            end else begin
              d.rep = 3'h0;
              d.obj = tmpl_pkg::obj_t'(nxt);
            end
          end
        end
      end
    endcase
    // observation of the emitted stream
    if (start) begin
      d.last_tag = 8'h00;
      d.seen_char = 1'b0;
      d.seen_cmd = 1'b0;
      d.seen_priv = 1'b0;
      d.pwr_seen = 3'h0;
      d.last_was_tag = 1'b0;
      d.char_next = 1'b0;
    end else if (fire) begin
      d.last_fired = q.tx_data;
      d.last_was_tag = q.tx_tag;
      d.char_next = q.last_was_tag && q.last_fired == tmpl_pkg::TAG_CHAR;
      if (q.tx_tag) begin
        d.last_tag = q.tx_data;
        d.seen_char = q.seen_char || q.tx_data == tmpl_pkg::TAG_CHAR;
        d.seen_cmd = q.seen_cmd || q.tx_data == tmpl_pkg::TAG_COMMANDS;
        d.seen_priv = q.seen_priv || (q.tx_data & tmpl_pkg::PRIVATE_TAG_MASK) == tmpl_pkg::PRIVATE_TAG_MASK;
        d.pwr_seen = q.pwr_seen + (q.tx_data == tmpl_pkg::TAG_PWR ? 3'h1 : 3'h0);
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= tmpl_pkg::ST_IDLE;
      q.obj <= tmpl_pkg::OBJ_CHAR;
      q.ctrl <= tmpl_pkg::CTRL_RESET;
      q.char_raw <= tmpl_pkg::CHAR_RESET;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign tx_data = q.tx_data;
  assign tx_valid = q.tx_valid;
  assign tx_last = q.tx_last;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // template header then its length
  hdr_tag_a: assert property (q.st == tmpl_pkg::ST_TAG && load |=>
    tx_valid && tx_data == tmpl_pkg::TAG_TEMPLATE && q.st == tmpl_pkg::ST_LEN)
    else $error("template tag not A5");
  hdr_len_a: assert property (q.st == tmpl_pkg::ST_LEN && load |=> tx_data == $past(total_len))
    else $error("template length wrong");
  // characteristics coding
  char_len_a: assert property (fire && q.last_was_tag && q.last_fired == tmpl_pkg::TAG_CHAR |->
    tx_data == tmpl_pkg::LEN_CHAR && !q.tx_tag)
    else $error("characteristics length not 01");
  char_resv_a: assert property (fire && q.char_next |->
    (tx_data & tmpl_pkg::CHAR_RESERVED_MASK) == 8'h00 && tx_data[6:4] == q.char_raw[6:4])
    else $error("characteristics byte reserved bits or classes wrong");
  // tag order keeps repeats grouped and privates last
  tag_order_a: assert property (fire && q.tx_tag |-> tx_data >= q.last_tag)
    else $error("nested tags out of order");
  priv_last_a: assert property (fire && q.tx_tag && tx_data <= tmpl_pkg::TAG_SECURE_TRANSPORT |-> !q.seen_priv)
    else $error("defined object after private object");
  // presence by file kind
  pwr_app_a: assert property (fire && q.tx_tag && tx_data == tmpl_pkg::TAG_PWR |-> kind == tmpl_pkg::KIND_APP)
    else $error("power object outside application directory");
  max_ber_a: assert property (fire && q.tx_tag && tx_data == tmpl_pkg::TAG_MAX_SIZE |->
    kind == tmpl_pkg::KIND_EF_BER)
    else $error("maximum size outside BER-TLV file");
  env_root_a: assert property (fire && q.tx_tag && tx_data == tmpl_pkg::TAG_ENV |->
    kind == tmpl_pkg::KIND_ROOT && q.ctrl[tmpl_pkg::CTRL_ENV_SUP_BIT])
    else $error("environment object misplaced");
  root_objs_a: assert property (fire && tx_last && kind == tmpl_pkg::KIND_ROOT |->
    q.seen_char && q.seen_cmd)
    else $error("root template missing characteristics or commands");
  pwr_count_a: assert property (fire && tx_last && kind == tmpl_pkg::KIND_APP |-> q.pwr_seen == npwr)
    else $error("power object count wrong");
endmodule

// ===== test/terminal_model.sv
`timescale 1ns/1ns
// terminal side: takes template bytes, may stall, latches the clock-stop policy
module terminal_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  input wire logic hold,
  input wire logic slow,
  input wire logic clr
);
  logic [7:0] got [0:31];
  int n;
  int last_at;
  logic done;
  logic ph;
  logic stop_ok_q;
  logic stop_high_q;
  logic [2:0] cls_q;
  // keeps the first 32 bytes in arrival order, repeated and private objects too
  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      n <= 0;
      last_at <= 0;
      done <= 1'b0;
      ph <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      ph <= !ph;
      tx_ready <= !hold && (!slow || ph); // stall when asked
      if (tx_valid && tx_ready) begin
        got[n] <= tx_data;
        n <= n + 1;
        if (tx_last) begin
          done <= 1'b1;
          last_at <= n + 1;
        end
      end
    end
  end
  // latch stop permission and level from the characteristics object
  always_ff @(posedge aclk) begin
    if (tx_valid && tx_ready && n == 4 && got[2] == tmpl_pkg::TAG_CHAR) begin
      stop_ok_q <= tx_data[0] ? (tx_data[3:2] != 2'b11) : (tx_data[3] ^ tx_data[2]);
      stop_high_q <= tx_data[0] ? !tx_data[3] : tx_data[2];
      cls_q <= tx_data[6:4];
    end
  end
endmodule

// ===== test/tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("mismatch %0t %h %h", $time, a, b); end end
module tb;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [7:0] n;
    logic [191:0] s;
  } row_t;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hold, slow, clr;
  logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_last, tx_ready;
  logic [7:0] awaddr, araddr, tx_data;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int errors = 0;
  int tests_run = 0;
  row_t rows [5];
  logic [15:0] dec [8] = '{16'h0008, 16'h0402, 16'h0804, 16'h1018, 16'h2028, 16'h4048, 16'h8307, 16'h0D08};
  // clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  template_encoder u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));
  terminal_model u_term (.aclk(aclk), .aresetn(aresetn), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .hold(hold), .slow(slow), .clr(clr));
  task give_verdict;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one write, address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // clear the terminal and start a template
  task go(input logic [31:0] c, input logic [3:0] s);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    wr(tmpl_pkg::ADDR_CTRL, c, s);
  endtask
  // wait for the last byte and compare the whole stream
  task chk(input row_t w);
    for (int i = 0; i < 300 && u_term.done !== 1'b1; i++) @(posedge aclk);
    `CHK(u_term.done, 1'b1)
    `CHK(u_term.n, int'(w.n))
    `CHK(u_term.last_at, int'(w.n))
    for (int i = 0; i < w.n; i++) `CHK(u_term.got[i], w.s[191-8*i -: 8])
  endtask
  // watchdog
  initial begin
    #(20 * 20000);
    errors++;
    give_verdict();
  end
  initial begin
    rows[0] = '{32'h0018_0100, 8'd14, {112'hA50C80017D870144880133C1015A, 80'h0}};
    rows[1] = '{32'h220F_0101, 8'd24, 192'hA51680017D8103100A20810330143282010A820114870144};
    rows[2] = '{32'h220F_0102, 8'd8, {64'hA50680017D870144, 128'h0}};
    rows[3] = '{32'h220F_0104, 8'd9, {72'hA50780017D86021122, 120'h0}};
    rows[4] = '{32'h0000_0103, 8'd2, {16'hA500, 176'h0}};
    {awvalid, wvalid, bready, arvalid, rready, hold, slow, clr} = 8'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(tmpl_pkg::ADDR_CHAR);
    `CHK(v[7:0], tmpl_pkg::CHAR_RESET)
    wr(tmpl_pkg::ADDR_CHAR, 32'hFF, 4'hF);
    rd(tmpl_pkg::ADDR_CHAR);
    `CHK(v[7:0], 8'h7D)
    wr(tmpl_pkg::ADDR_MISC, 32'h1122_3344, 4'hF);
    wr(tmpl_pkg::ADDR_PRIV, 32'h0000_5A01, 4'hF);
    wr(8'h20, 32'h0010_0A20, 4'hF);
    wr(8'h24, 32'h0030_1432, 4'hF);
    wr(8'h40, 32'h0A, 4'hF);
    wr(8'h44, 32'h14, 4'hF);
    `CHK(r, tmpl_pkg::RESP_OKAY)
    wr(8'hF0, 32'h0, 4'hF);
    `CHK(r, tmpl_pkg::RESP_SLVERR)
    rd(8'hF0);
    `CHK(r, tmpl_pkg::RESP_SLVERR)
    rd(8'h24);
    `CHK(v, 32'h0030_1432)
    `CHK(r, tmpl_pkg::RESP_OKAY)
    // every file kind, stalling terminal on odd rows
    for (int k = 0; k < 5; k++) begin
      slow <= k[0];
      go(rows[k].ctrl, 4'hF);
      chk(rows[k]);
      rd(tmpl_pkg::ADDR_STATUS);
      `CHK(v[15:8], rows[k].n - 8'd2)
    end
    // terminal latched 7D: reserved level code, no stop, all classes
    `CHK(u_term.stop_ok_q, 1'b0)
    `CHK(u_term.stop_high_q, 1'b0)
    `CHK(u_term.cls_q, 3'h7)
    // start without the strobe of its byte does nothing
    go(rows[0].ctrl, 4'hD);
    rd(tmpl_pkg::ADDR_STATUS);
    `CHK(v[0], 1'b0)
    `CHK(u_term.n, 0)
    // a second start while busy is ignored
    hold <= 1'b1;
    go(rows[4].ctrl, 4'hF);
    wr(tmpl_pkg::ADDR_CTRL, rows[1].ctrl, 4'hF);
    rd(tmpl_pkg::ADDR_STATUS);
    `CHK(v[0], 1'b1)
    hold <= 1'b0;
    chk(rows[4]);
    // clock-stop and supply class decode
    for (int k = 0; k < 8; k++) begin
      wr(tmpl_pkg::ADDR_CHAR, {24'h0, dec[k][15:8]}, 4'hF);
      rd(tmpl_pkg::ADDR_STATUS);
      `CHK(v[7:1], dec[k][6:0])
    end
    // reset in mid-template drops the stream and the registers
    hold <= 1'b1;
    go(rows[0].ctrl, 4'hF);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK(tx_valid, 1'b0)
    aresetn <= 1'b1;
    hold <= 1'b0;
    @(posedge aclk);
    rd(tmpl_pkg::ADDR_CHAR);
    `CHK(v[7:0], tmpl_pkg::CHAR_RESET)
    give_verdict();
  end
endmodule
